// *** hdl/ssi_encoder_feedback_status.sv ***
// Implementation choice: the APB register port.
`timescale 1ns/100ps
// How it works
// [R01] Feedback image is six bytes: four position bytes, two status bytes.
// [R02] Position bits 0 to 30 carry the encoder position.
// [R03] Position bit 31 is set while a latched value is shown.
// [R04] Ready flag, byte 4 bit 6, only while encoder communication works.
// [R05] Byte 4 bit 4 flags wire break or parity error.
// [R06] Fault flags stay set until explicitly cleared.
// [R07] Byte 4 bit 3 flags a 24 V encoder supply fault.
// [R08] Byte 4 bit 2 mirrors the latch input level.
// [R09] Byte 4 bit 1 set while movement is negative.
// [R10] Byte 4 bit 0 set while movement is positive.
// [R11] Byte 5 bit 3 shows comparator 1 result.
// [R12] Byte 5 bit 2 shows comparator 2 result.
// [R13] Byte 5 bit 1 set when a reference load fails.
// [R14] Both load request bits at zero clear the loading error.
// [R15] Byte 5 bit 0 set while a reference load runs.
// [R16] Control bit 7 clears the latched fault flags.
// [R17] Selected latch edge captures position, held until latch reset.
// [R18] A load request bit starts moving the preset to its comparator.
// [R19] New reference activates after request cleared and running fell.
// [R20] Reserved status bits read zero.
// [R21] Direction flags never both set; both clear when position is unchanged.
module ssi_encoder_feedback_status (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire ssi_fb_pkg::enc_in_t enc_in,
    input  wire logic               latch_input,
    output ssi_fb_pkg::cmp_out_t    cmp1_out,
    output ssi_fb_pkg::cmp_out_t    cmp2_out
);
    import ssi_fb_pkg::*;
`include "ssi_fb_regs.svh"

    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic        lat_s1_r, lat_s2_r, lat_s3_r, latch_edge;
    logic [30:0] prev_pos_r, prev_pos_nxt;
    logic        moving_positive_flag_r, moving_positive_flag_nxt;
    logic        moving_negative_flag_r, moving_negative_flag_nxt;
    logic        enc_fault_r, enc_fault_nxt, sup_fault_r, sup_fault_nxt;
    logic        latched_r, latched_nxt;
    logic [30:0] latch_val_r, latch_val_nxt;
    load_state_t state_r, state_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic        sel2_r, sel2_nxt, ld_err_r, ld_err_nxt;
    logic [30:0] pend_r, pend_nxt;
    cmp_out_t    cmp1_r, cmp1_nxt, cmp2_r, cmp2_nxt;
    logic [1:0]  req;
    logic [31:0] pos_img_r, pos_img_nxt;
    logic [7:0]  st4_r, st4_nxt, st5_r, st5_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [31:0] preset_r, preset_nxt;
    logic [7:0]  ctrl_r, ctrl_nxt;
    logic [1:0]  lcfg_r, lcfg_nxt;
    logic        setup, wr_take, hit, ro_hit;
    logic [31:0] rd_word;

    assign prdata   = prdata_r;
    assign pready   = pready_r;
    assign pslverr  = pslverr_r;
    assign cmp1_out = cmp1_r;
    assign cmp2_out = cmp2_r;
    assign req      = {ctrl_r[`CTL_LOAD2], ctrl_r[`CTL_LOAD1]};

    ////////////////////////////////////////////////////////////////////
    // Latch pin synchroniser, second and third stages feed logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_s1_r <= 1'b0;
            lat_s2_r <= 1'b0;
            lat_s3_r <= 1'b0;
        end else begin
            lat_s1_r <= latch_input;
            lat_s2_r <= lat_s1_r;
            lat_s3_r <= lat_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Direction, faults and latch
    always_comb begin
        unique case (lcfg_r)
            `LATCH_RISE: latch_edge = lat_s2_r & ~lat_s3_r;
            `LATCH_FALL: latch_edge = ~lat_s2_r & lat_s3_r;
            `LATCH_BOTH: latch_edge = lat_s2_r ^ lat_s3_r;
            default:     latch_edge = 1'b0;
        endcase
        prev_pos_nxt             = prev_pos_r;
        moving_positive_flag_nxt = moving_positive_flag_r;
        moving_negative_flag_nxt = moving_negative_flag_r;
        if (enc_in.strobe) begin
            prev_pos_nxt = enc_in.pos;
            // Strict compares keep the flags exclusive [R09] [R10] [R21]
            moving_positive_flag_nxt = enc_in.pos > prev_pos_r;
            moving_negative_flag_nxt = enc_in.pos < prev_pos_r;
        end
        // Set wins over the clear bit [R05] [R06] [R16]
        enc_fault_nxt = (enc_fault_r & ~ctrl_r[`CTL_FAULT_RST])
                      | enc_in.wire_break | enc_in.parity_err;
        sup_fault_nxt = (sup_fault_r & ~ctrl_r[`CTL_FAULT_RST])
                      | enc_in.supply_fault; // [R07] [R06] [R16]
        latched_nxt   = latched_r & ~ctrl_r[`CTL_LATCH_RST]; // [R17]
        latch_val_nxt = latch_val_r;
        // Later edges ignored while a value is held
        if (latch_edge && !latched_r) begin
            latched_nxt   = 1'b1; // [R17]
            latch_val_nxt = enc_in.pos;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_pos_r             <= 31'h00000000;
            moving_positive_flag_r <= 1'b0;
            moving_negative_flag_r <= 1'b0;
            enc_fault_r            <= 1'b0;
            sup_fault_r            <= 1'b0;
            latched_r              <= 1'b0;
            latch_val_r            <= 31'h00000000;
        end else begin
            prev_pos_r             <= prev_pos_nxt;
            moving_positive_flag_r <= moving_positive_flag_nxt;
            moving_negative_flag_r <= moving_negative_flag_nxt;
            enc_fault_r            <= enc_fault_nxt;
            sup_fault_r            <= sup_fault_nxt;
            latched_r              <= latched_nxt;
            latch_val_r            <= latch_val_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reference loading
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        sel2_nxt   = sel2_r;
        ld_err_nxt = ld_err_r;
        pend_nxt   = pend_r;
        cmp1_nxt   = cmp1_r;
        cmp2_nxt   = cmp2_r;
        unique case (state_r)
            LD_IDLE: begin
                if (req != 2'h0) begin
                    // Both at once, or bit 31 set, cannot be loaded
                    if (req == 2'h3 || preset_r[31]) begin
                        ld_err_nxt = 1'b1; // [R13]
                        state_nxt  = LD_WAIT;
                    end else begin
                        sel2_nxt  = req[1]; // [R18]
                        pend_nxt  = preset_r[30:0];
                        cnt_nxt   = `LOAD_CYCLES - 4'h1;
                        state_nxt = LD_RUN; // [R15]
                    end
                end
            end
            LD_RUN: begin
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h0) begin
                    state_nxt = LD_WAIT;
                end
            end
            LD_WAIT: begin
                if (req == 2'h0) begin
                    state_nxt = LD_IDLE;
                    // Old reference stays in force until now [R19]
                    if (!ld_err_r && sel2_r) begin
                        cmp2_nxt = {1'b1, pend_r};
                    end else if (!ld_err_r) begin
                        cmp1_nxt = {1'b1, pend_r};
                    end
                end
            end
        endcase
        if (req == 2'h0) begin
            ld_err_nxt = 1'b0; // [R14]
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r  <= LD_IDLE;
            cnt_r    <= 4'h0;
            sel2_r   <= 1'b0;
            ld_err_r <= 1'b0;
            pend_r   <= 31'h00000000;
            cmp1_r   <= 32'h00000000;
            cmp2_r   <= 32'h00000000;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            sel2_r   <= sel2_nxt;
            ld_err_r <= ld_err_nxt;
            pend_r   <= pend_nxt;
            cmp1_r   <= cmp1_nxt;
            cmp2_r   <= cmp2_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Feedback image, reserved bits left at zero [R01] [R20]
    always_comb begin
        pos_img_nxt = latched_r ? {1'b1, latch_val_r}  // [R03]
                                : {1'b0, enc_in.pos};  // [R02]
        st4_nxt = 8'h00;
        st4_nxt[`ST4_READY]     = enc_in.comm_ok & ~enc_fault_r
                                & ~sup_fault_r;        // [R04]
        st4_nxt[`ST4_ENC_FLT]   = enc_fault_r;         // [R05]
        st4_nxt[`ST4_SUP_FLT]   = sup_fault_r;         // [R07]
        st4_nxt[`ST4_LATCH_LVL] = lat_s2_r;            // [R08]
        st4_nxt[`ST4_NEG]       = moving_negative_flag_r; // [R09]
        st4_nxt[`ST4_POS]       = moving_positive_flag_r; // [R10]
        st5_nxt = 8'h00;
        st5_nxt[`ST5_CMP1]   = enc_in.cmp1_hit;        // [R11]
        st5_nxt[`ST5_CMP2]   = enc_in.cmp2_hit;        // [R12]
        st5_nxt[`ST5_LD_ERR] = ld_err_r;               // [R13]
        st5_nxt[`ST5_LD_RUN] = state_r == LD_RUN;      // [R15]
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_img_r <= 32'h00000000;
            st4_r     <= 8'h00;
            st5_r     <= 8'h00;
        end else begin
            pos_img_r <= pos_img_nxt;
            st4_r     <= st4_nxt;
            st5_r     <= st5_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave: one wait-free access cycle, read data captured at setup
    assign setup   = psel & ~penable;
    assign wr_take = psel & penable & pready_r & pwrite & ~pslverr_r;
    always_comb begin
        hit     = 1'b1;
        // Every mapped word below the preset is a read-only image
        ro_hit  = paddr < `ADDR_OF(`IDX_PRESET);
        rd_word = 32'h00000000;
        unique case (paddr)
            `ADDR_OF(`IDX_POS):       rd_word = pos_img_r;
            `ADDR_OF(`IDX_STAT4):     rd_word = {24'h000000, st4_r};
            `ADDR_OF(`IDX_STAT5):     rd_word = {24'h000000, st5_r};
            `ADDR_OF(`IDX_PRESET):    rd_word = preset_r;
            `ADDR_OF(`IDX_CTRL):      rd_word = {24'h000000, ctrl_r};
            `ADDR_OF(`IDX_LATCH_CFG): rd_word = {30'h00000000, lcfg_r};
            default:                  hit     = 1'b0;
        endcase
    end
    always_comb begin
        pready_nxt  = setup;
        prdata_nxt  = prdata_r;
        pslverr_nxt = pslverr_r;
        preset_nxt  = preset_r;
        ctrl_nxt    = ctrl_r;
        lcfg_nxt    = lcfg_r;
        if (setup) begin
            pslverr_nxt = ~hit | (pwrite & ro_hit);
            prdata_nxt  = pwrite ? 32'h00000000 : rd_word;
        end
        if (wr_take) begin
            unique case (paddr)
                `ADDR_OF(`IDX_PRESET): preset_nxt = pwdata;
                `ADDR_OF(`IDX_CTRL):   ctrl_nxt = pwdata[7:0] & `CTL_MASK;
                `ADDR_OF(`IDX_LATCH_CFG): lcfg_nxt = pwdata[1:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            preset_r  <= `RST_PRESET;
            ctrl_r    <= `RST_CTRL;
            lcfg_r    <= `RST_LATCH_CFG;
        end else begin
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            preset_r  <= preset_nxt;
            ctrl_r    <= ctrl_nxt;
            lcfg_r    <= lcfg_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_LATCH_FLAG: assert property ( // [R03]
        pos_img_r[`POS_LATCH_BIT] == $past(latched_r))
        else $error("latch flag does not follow latch state");
    AST_READY: assert property ( // [R04]
        st4_r[`ST4_READY] |-> $past(enc_in.comm_ok) && !$past(enc_fault_r))
        else $error("ready shown without working link");
    AST_FAULT_SET: assert property ( // [R05]
        (enc_in.wire_break || enc_in.parity_err) |=> ##1 st4_r[`ST4_ENC_FLT])
        else $error("encoder fault not flagged");
    AST_FAULT_HOLD: assert property ( // [R06]
        enc_fault_r && !ctrl_r[`CTL_FAULT_RST] |=> enc_fault_r)
        else $error("encoder fault dropped without reset");
    AST_FAULT_CLR: assert property ( // [R16]
        sup_fault_r && ctrl_r[`CTL_FAULT_RST] && !enc_in.supply_fault
        |=> !sup_fault_r)
        else $error("supply fault not cleared");
    AST_DIR_EXCL: assert property ( // [R21]
        !(st4_r[`ST4_NEG] && st4_r[`ST4_POS]))
        else $error("both direction flags set");
    AST_RESERVED: assert property ( // [R20]
        st4_r[7] == 1'b0 && st4_r[5] == 1'b0 && st5_r[7:4] == 4'h0)
        else $error("reserved status bit set");
    AST_LOAD_RUN: assert property ( // [R15]
        state_r == LD_IDLE && req == 2'h1 && !preset_r[31]
        |-> ##2 st5_r[`ST5_LD_RUN] ##[1:20] !st5_r[`ST5_LD_RUN])
        else $error("loading running flag wrong");
    AST_ERR_CLR: assert property ( // [R14]
        ld_err_r && req == 2'h0 |=> !ld_err_r)
        else $error("loading error not cleared");
    AST_ACTIVATE: assert property ( // [R19]
        $rose(cmp1_r.active)
        |-> $past(req) == 2'h0 && $past(state_r) == LD_WAIT)
        else $error("comparator activated too early");
    AST_LATCH_HOLD: assert property ( // [R17]
        latched_r && !ctrl_r[`CTL_LATCH_RST]
        |=> latched_r && $stable(latch_val_r))
        else $error("latched value not held");

endmodule : ssi_encoder_feedback_status

// *** hdl/ssi_fb_pkg.sv ***
package ssi_fb_pkg;

    // Signals from the encoder front end, same clock
    typedef struct packed {
        logic [30:0] pos;
        logic        strobe;
        logic        comm_ok;
        logic        wire_break;
        logic        parity_err;
        logic        supply_fault;
        logic        cmp1_hit;
        logic        cmp2_hit;
    } enc_in_t;

    // Reference handed to one comparator
    typedef struct packed {
        logic        active;
        logic [30:0] ref_value;
    } cmp_out_t;

    typedef enum logic [1:0] {
        LD_IDLE,
        LD_RUN,
        LD_WAIT
    } load_state_t;

endpackage : ssi_fb_pkg

// *** hdl/ssi_fb_regs.svh ***
`ifndef SSI_FB_REGS_SVH
`define SSI_FB_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_POS        8'h00
`define IDX_STAT4      8'h04
`define IDX_STAT5      8'h05
`define IDX_PRESET     8'h08
`define IDX_CTRL       8'h09
`define IDX_LATCH_CFG  8'h0A
`define ADDR_OF(i)     (8'((i) * 4))

// Feedback field positions
`define POS_LATCH_BIT  31
`define ST4_READY      6
`define ST4_ENC_FLT    4
`define ST4_SUP_FLT    3
`define ST4_LATCH_LVL  2
`define ST4_NEG        1
`define ST4_POS        0
`define ST5_CMP1       3
`define ST5_CMP2       2
`define ST5_LD_ERR     1
`define ST5_LD_RUN     0

// Control field positions
`define CTL_LOAD1      0
`define CTL_LOAD2      1
`define CTL_LATCH_RST  6
`define CTL_FAULT_RST  7
`define CTL_MASK       8'hC3

// Latch edge selection
`define LATCH_OFF      2'h0
`define LATCH_RISE     2'h1
`define LATCH_FALL     2'h2
`define LATCH_BOTH     2'h3

// Reset values
`define RST_PRESET     32'h00000000
`define RST_CTRL       8'h00
`define RST_LATCH_CFG  2'h0

// Reference load duration
`define LOAD_TIME_NS   1000
`define CLK_PERIOD_NS  100
`define LOAD_CYCLES    (4'((`LOAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`endif

// *** tb/enc_front_model.sv ***
`timescale 1ns/100ps
module enc_front_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [30:0] target,
    input  wire logic        sample_req,
    input  wire logic [5:0]  flags,
    output ssi_fb_pkg::enc_in_t enc_in
);
    import ssi_fb_pkg::*;

    // Flags: comm_ok, wire_break, parity_err, supply_fault, cmp1, cmp2
    // Registered like a real front end, so status sees one extra stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enc_in <= '0;
        end else begin
            enc_in.strobe <= sample_req;
            if (sample_req) begin
                enc_in.pos <= target;
            end
            {enc_in.comm_ok, enc_in.wire_break, enc_in.parity_err,
             enc_in.supply_fault, enc_in.cmp1_hit, enc_in.cmp2_hit} <= flags;
        end
    end
endmodule : enc_front_model

// *** tb/test_ssi_encoder_feedback_status.sv ***
`timescale 1ns/100ps
`include "ssi_fb_regs.svh"
module test_ssi_encoder_feedback_status;
    import ssi_fb_pkg::*;

    logic        pclk = 1'b0;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    enc_in_t     enc_in;
    logic        latch_input;
    cmp_out_t    cmp1_out;
    cmp_out_t    cmp2_out;
    logic [30:0] target;
    logic        sample_req;
    logic [5:0]  flags;
    logic [31:0] rd;
    logic        er;
    cmp_out_t    c;
    int          errors = 0;
    int          samples_checked = 0;

    localparam logic [7:0] A_POS = `ADDR_OF(`IDX_POS);
    localparam logic [7:0] A_ST4 = `ADDR_OF(`IDX_STAT4);
    localparam logic [7:0] A_ST5 = `ADDR_OF(`IDX_STAT5);
    localparam logic [7:0] A_PRE = `ADDR_OF(`IDX_PRESET);
    localparam logic [7:0] A_CTL = `ADDR_OF(`IDX_CTRL);
    localparam logic [7:0] A_CFG = `ADDR_OF(`IDX_LATCH_CFG);
    localparam logic [7:0] A_RO [3] = '{A_POS, A_ST4, A_ST5};

    always #50 pclk = ~pclk;

    ssi_encoder_feedback_status ssi_encoder_feedback_status_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .enc_in(enc_in),
        .latch_input(latch_input), .cmp1_out(cmp1_out),
        .cmp2_out(cmp2_out)
    );

    enc_front_model enc_front_model_i (
        .pclk(pclk), .presetn(presetn), .target(target),
        .sample_req(sample_req), .flags(flags), .enc_in(enc_in)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t ns: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // Request held until pready is sampled high; no wait count assumed
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            $display("unexpected at %0t ns: no pready", $time);
            give_verdict();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e, input string what);
        apb(1'b0, a, 32'h0);
        check(rd & m, e, what);
        check(32'(er), 32'h0, "read refused");
    endtask : rd_chk

    task automatic move(input logic [30:0] p);
        @(posedge pclk);
        target <= p;
        sample_req <= 1'b1;
        @(posedge pclk);
        sample_req <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : move

    ////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        latch_input = 1'b0;
        target = '0;
        sample_req = 1'b0;
        flags = 6'h00;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;

        rd_chk(A_PRE, 32'hFFFFFFFF, `RST_PRESET, "preset reset");
        rd_chk(A_CTL, 32'hFFFFFFFF, 32'(`RST_CTRL), "ctrl reset");
        rd_chk(A_CFG, 32'hFFFFFFFF, 32'(`RST_LATCH_CFG), "cfg reset");
        rd_chk(A_ST4, 32'hFFFFFFFF, 32'h0, "no link, not ready");
        apb(1'b0, 8'h30, 32'h0);
        check(32'(er), 32'h1, "unmapped read");
        foreach (A_RO[i]) begin
            apb(1'b1, A_RO[i], 32'hFFFFFFFF);
            check(32'(er), 32'h1, "write to read-only");
        end
        $display("Test reset and map done");

        flags <= 6'b100000;
        move(31'd100);
        rd_chk(A_POS, 32'hFFFFFFFF, 32'd100, "position");
        rd_chk(A_ST4, 32'hFFFFFFFF, 32'h41, "ready, up");
        move(31'd50);
        rd_chk(A_ST4, 32'hFFFFFFFF, 32'h42, "down");
        move(31'd50);
        rd_chk(A_ST4, 32'hFFFFFFFF, 32'h40, "standstill");
        $display("Test direction done");

        // One-cycle pulses prove the flags are held, not mirrored
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk);
            flags <= 6'b100000 | (6'h10 >> i);
            @(posedge pclk);
            flags <= 6'b100000;
            repeat (4) @(posedge pclk);
            rd_chk(A_ST4, 32'h18, (i == 2) ? 32'h08 : 32'h10,
                   "fault held");
            apb(1'b1, A_CTL, 32'h80);
            apb(1'b1, A_CTL, 32'h00);
            rd_chk(A_ST4, 32'h58, 32'h40, "fault cleared");
        end
        $display("Test faults done");

        latch_input <= 1'b1;
        repeat (6) @(posedge pclk);
        rd_chk(A_ST4, 32'h04, 32'h04, "latch input level");
        latch_input <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b1, A_CFG, 32'(`LATCH_RISE));
        rd_chk(A_CFG, 32'hFFFFFFFF, 32'(`LATCH_RISE), "cfg rw");
        move(31'd200);
        latch_input <= 1'b1;
        repeat (6) @(posedge pclk);
        move(31'd300);
        rd_chk(A_POS, 32'hFFFFFFFF, 32'h800000C8, "latched");
        apb(1'b1, A_CTL, 32'h40);
        apb(1'b1, A_CTL, 32'h00);
        rd_chk(A_POS, 32'hFFFFFFFF, 32'd300, "latch reset");
        // Falling edge from the high level, then both edges with a rising edge
        for (int m = 2; m < 4; m++) begin
            apb(1'b1, A_CFG, 32'(m));
            move(31'(400 + m));
            latch_input <= ~latch_input;
            repeat (6) @(posedge pclk);
            move(31'd500);
            rd_chk(A_POS, 32'hFFFFFFFF, 32'h80000190 + m, "edge");
            apb(1'b1, A_CTL, 32'h40);
            apb(1'b1, A_CTL, 32'h00);
        end
        $display("Test latch done");

        for (int k = 0; k < 2; k++) begin
            apb(1'b1, A_PRE, 32'h1234 + k);
            rd_chk(A_PRE, 32'hFFFFFFFF, 32'h1234 + k, "preset rw");
            apb(1'b1, A_CTL, 32'h1 << k);
            @(posedge pclk); // Running shows two edges after the write
            rd_chk(A_ST5, 32'h01, 32'h01, "load running");
            repeat (15) @(posedge pclk);
            rd_chk(A_ST5, 32'h03, 32'h00, "load ended");
            c = k ? cmp2_out : cmp1_out;
            check(32'(c.active), 32'h0, "active too early");
            apb(1'b1, A_CTL, 32'h0);
            repeat (3) @(posedge pclk);
            c = k ? cmp2_out : cmp1_out;
            check(c, 32'h80001234 + k, "reference loaded");
        end
        // Both request bits, then a preset with bit 31 set
        apb(1'b1, A_PRE, 32'h80000000);
        for (int t = 0; t < 2; t++) begin
            apb(1'b1, A_CTL, t ? 32'h01 : 32'h03);
            repeat (3) @(posedge pclk);
            rd_chk(A_ST5, 32'h02, 32'h02, "load error");
            apb(1'b1, A_CTL, 32'h00);
            repeat (3) @(posedge pclk);
            rd_chk(A_ST5, 32'h02, 32'h00, "load error cleared");
        end
        check(cmp1_out, 32'h80001234, "reference kept");
        $display("Test load done");

        for (int j = 0; j < 2; j++) begin
            @(posedge pclk);
            flags <= 6'b100000 | (6'h2 >> j);
            repeat (4) @(posedge pclk);
            rd_chk(A_ST5, 32'hFC, 32'h08 >> j, "compare");
        end
        $display("Test comparators done");
        give_verdict();
    end

endmodule : test_ssi_encoder_feedback_status
